/* src/scdr_consts.vh */
`ifndef SCDR_CONSTS_VH
`define SCDR_CONSTS_VH

// Printed register offsets, used as register indices
`define SCDR_IDX_CTRL 32'h50001200
`define SCDR_IDX_DATA_LO 32'h50001202
`define SCDR_IDX_DATA_HI 32'h50001204
`define SCDR_IDX_IRQ_CLR 32'h50001206
`define SCDR_IDX_DIVIDER 32'h50001210
// Index bits decoded from the bus address
`define SCDR_IDX_MASK 32'h00000fff

// Control field positions
`define SCDR_B_SS_GATE 15
`define SCDR_B_IRQ_MASK 14
`define SCDR_B_INT 13
`define SCDR_B_PIN_SAMPLE 12
`define SCDR_B_TX_FULL 11
`define SCDR_B_FORCE_DO 10
`define SCDR_B_SOFT_RST 9
`define SCDR_B_WORD_HI 8
`define SCDR_B_WORD_LO 7
`define SCDR_B_ROLE 6
`define SCDR_B_DO_LEVEL 5
`define SCDR_B_CLK_HI 4
`define SCDR_B_CLK_LO 3
`define SCDR_B_POL 2
`define SCDR_B_PHA 1
`define SCDR_B_ENABLE 0

// Writable control bits and reset values
`define SCDR_CTRL_RW_MASK 16'hc7ff
`define SCDR_CTRL_RESET 16'h0000
`define SCDR_DATA_RESET 16'h0000
`define SCDR_DIV_RESET 8'h01

// Word length codes
`define SCDR_WORD_8 2'h0
`define SCDR_WORD_16 2'h1
`define SCDR_WORD_32 2'h2
`define SCDR_WORD_9 2'h3

// Half serial clock period per divider unit, per clock code
`define SCDR_HALF_CODE0 3'h4
`define SCDR_HALF_CODE1 3'h2
`define SCDR_HALF_CODE2 3'h1
`define SCDR_HALF_CODE3 3'h7

// Bus responses
`define SCDR_RESP_OKAY 2'h0
`define SCDR_RESP_SLVERR 2'h2

`endif

/* src/scdr_top.v */
`timescale 1ns/1ps
`include "scdr_consts.vh"

module scdr_top #(
  parameter ADDR_W = 16,
  parameter PTR_W = 2,
  parameter DIV_W = 8,
  parameter SLAVE_OK = 1
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // AXI4-Lite write
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  // Serial pins
  output wire sclk_o,
  output wire sclk_oe_n,
  input wire sclk_i,
  output wire serial_out_pin,
  output wire serial_out_oe_n,
  input wire serial_in_pin,
  input wire slave_sel_n,
  // Interrupt request
  output wire irq
);

  localparam DEPTH = 1 << PTR_W;
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg [15:0] ctrl_q;
  reg [DIV_W-1:0] clock_period_divider_q;
  reg [15:0] hi_stage_q;
  reg int_q;
  reg st_q;
  reg [6:0] edge_q;
  reg [31:0] tx_sh_q;
  reg [31:0] rx_sh_q;
  reg out_q;
  reg sclk_q;
  reg [DIV_W+2:0] half_cnt_q;
  reg din_s1_q, din_s2_q;
  reg sck_s1_q, sck_s2_q, sck_s3_q;
  reg ss_s1_q, ss_s2_q;
  reg [31:0] tx_mem_q [0:DEPTH-1];
  reg [31:0] rx_mem_q [0:DEPTH-1];
  reg [PTR_W-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  reg [PTR_W:0] tx_cnt_q, rx_cnt_q;
  reg aw_held_q, w_held_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  // Control fields
  wire slave_mode = ctrl_q[`SCDR_B_ROLE] & (SLAVE_OK != 0);
  wire master_mode = ~slave_mode;
  wire pol = ctrl_q[`SCDR_B_POL];
  wire pha = ctrl_q[`SCDR_B_PHA];
  wire [1:0] word_code = {ctrl_q[`SCDR_B_WORD_HI], ctrl_q[`SCDR_B_WORD_LO]};
  reg [5:0] word_len;
  always @*
  begin
    case (word_code)
      `SCDR_WORD_8: word_len = 6'd8;
      `SCDR_WORD_16: word_len = 6'd16;
      `SCDR_WORD_32: word_len = 6'd32;
      default: word_len = master_mode ? 6'd9 : 6'd8;
    endcase
  end

  // FIFO state
  wire tx_full = (tx_cnt_q == DEPTH[PTR_W:0]);
  wire tx_empty = (tx_cnt_q == {(PTR_W+1){1'b0}});
  wire rx_full = (rx_cnt_q == DEPTH[PTR_W:0]);
  wire rx_empty = (rx_cnt_q == {(PTR_W+1){1'b0}});
  wire [31:0] tx_head = tx_mem_q[tx_rp_q];
  wire [31:0] rx_head = rx_mem_q[rx_rp_q];

  // Switch-off and soft reset
  wire keep_alive = master_mode & ((st_q == ST_RUN) | ~tx_empty);
  wire kill = ctrl_q[`SCDR_B_SOFT_RST] | (~ctrl_q[`SCDR_B_ENABLE] & ~keep_alive);

  // Pin synchronisers
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      ss_s1_q <= 1'b1;
      ss_s2_q <= 1'b1;
    end
    else
    begin
      din_s1_q <= serial_in_pin;
      din_s2_q <= din_s1_q;
      sck_s1_q <= sclk_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      ss_s1_q <= slave_sel_n;
      ss_s2_q <= ss_s1_q;
    end
  end

  wire selected = ~ctrl_q[`SCDR_B_SS_GATE] | ~ss_s2_q;

  // Master clock divider
  reg [2:0] half_mult;
  always @*
  begin
    case ({ctrl_q[`SCDR_B_CLK_HI], ctrl_q[`SCDR_B_CLK_LO]})
      2'h0: half_mult = `SCDR_HALF_CODE0;
      2'h1: half_mult = `SCDR_HALF_CODE1;
      2'h2: half_mult = `SCDR_HALF_CODE2;
      default: half_mult = `SCDR_HALF_CODE3;
    endcase
  end
  wire [DIV_W-1:0] div_eff = (clock_period_divider_q == {DIV_W{1'b0}}) ?
    {{(DIV_W-1){1'b0}}, 1'b1} : clock_period_divider_q;
  wire [DIV_W+2:0] half_len = div_eff * half_mult;
  wire m_tick = (st_q == ST_RUN) & (half_cnt_q == half_len - 1'b1);

  // Edge events
  wire s_edge = slave_mode & (st_q == ST_RUN) & (sck_s2_q ^ sck_s3_q);
  wire any_edge = master_mode ? m_tick : s_edge;
  wire lead = master_mode ? ~sclk_q : (sck_s2_q != pol);
  wire last_edge = (edge_q == {word_len, 1'b0} - 7'd1);
  wire do_sample = any_edge & (lead ^ pha);
  wire do_launch = any_edge & ((lead & pha) | (~lead & ~pha & ~last_edge));
  wire done = any_edge & ~lead & last_edge;
  wire [31:0] rx_next = do_sample ? {rx_sh_q[30:0], din_s2_q} : rx_sh_q;

  // Start conditions
  wire m_start = master_mode & (st_q == ST_IDLE) & ~tx_empty & ~rx_full;
  wire s_start = slave_mode & (st_q == ST_IDLE) & ctrl_q[`SCDR_B_ENABLE] & selected;
  wire start = ~kill & (m_start | s_start);
  wire [31:0] tx_src = tx_empty ? 32'h00000000 : tx_head;
  wire [31:0] tx_aligned = tx_src << (7'd32 - {1'b0, word_len});
  wire tx_pop = start & ~tx_empty;
  wire rx_push = ~kill & done & ~rx_full;
  wire s_abort = slave_mode & (st_q == ST_RUN) & ~selected;

  // Shift engine
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      edge_q <= 7'd0;
      tx_sh_q <= 32'h00000000;
      rx_sh_q <= 32'h00000000;
      out_q <= 1'b0;
      sclk_q <= 1'b0;
      half_cnt_q <= {(DIV_W+3){1'b0}};
    end
    else if (kill)
    begin
      st_q <= ST_IDLE;
      edge_q <= 7'd0;
      tx_sh_q <= 32'h00000000;
      sclk_q <= 1'b0;
      half_cnt_q <= {(DIV_W+3){1'b0}};
    end
    else if (start)
    begin
      st_q <= ST_RUN;
      edge_q <= 7'd0;
      sclk_q <= 1'b0;
      half_cnt_q <= {(DIV_W+3){1'b0}};
      if (pha)
        tx_sh_q <= tx_aligned;
      else
      begin
        out_q <= tx_aligned[31];
        tx_sh_q <= {tx_aligned[30:0], 1'b0};
      end
    end
    else if (s_abort)
    begin
      st_q <= ST_IDLE;
      edge_q <= 7'd0;
    end
    else if (st_q == ST_RUN)
    begin
      half_cnt_q <= m_tick ? {(DIV_W+3){1'b0}} : half_cnt_q + 1'b1;
      if (m_tick)
        sclk_q <= ~sclk_q;
      if (any_edge)
        edge_q <= edge_q + 7'd1;
      rx_sh_q <= rx_next;
      if (do_launch)
      begin
        out_q <= tx_sh_q[31];
        tx_sh_q <= {tx_sh_q[30:0], 1'b0};
      end
      if (done)
        st_q <= ST_IDLE;
    end
  end

  // Pin drive
  wire busy = (st_q == ST_RUN);
  assign sclk_o = pol ^ sclk_q;
  assign sclk_oe_n = ~master_mode;
  assign serial_out_pin = (ctrl_q[`SCDR_B_FORCE_DO] | ~busy) ?
    ctrl_q[`SCDR_B_DO_LEVEL] : out_q;
  assign serial_out_oe_n = slave_mode & ~selected;

  // Bus handshakes
  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
  wire [31:0] wr_idx = {{(32-ADDR_W+2){1'b0}}, aw_addr_q[ADDR_W-1:2]};
  wire [31:0] rd_idx = {{(32-ADDR_W+2){1'b0}}, s_axi_araddr[ADDR_W-1:2]};
  wire wr_ctrl = wr_go & (wr_idx == (`SCDR_IDX_CTRL & `SCDR_IDX_MASK));
  wire wr_lo = wr_go & (wr_idx == (`SCDR_IDX_DATA_LO & `SCDR_IDX_MASK));
  wire wr_hi = wr_go & (wr_idx == (`SCDR_IDX_DATA_HI & `SCDR_IDX_MASK));
  wire wr_clr = wr_go & (wr_idx == (`SCDR_IDX_IRQ_CLR & `SCDR_IDX_MASK));
  wire wr_div = wr_go & (wr_idx == (`SCDR_IDX_DIVIDER & `SCDR_IDX_MASK));
  wire wr_hit = wr_ctrl | wr_lo | wr_hi | wr_clr | wr_div;
  wire rd_lo = rd_go & (rd_idx == (`SCDR_IDX_DATA_LO & `SCDR_IDX_MASK));
  wire tx_push = wr_lo & ~tx_full & ~kill;
  wire rx_pop = rd_lo & ~rx_empty & ~kill;
  wire [15:0] byte_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [15:0] ctrl_wmask = byte_mask & `SCDR_CTRL_RW_MASK;
  wire int_rd = int_q & ~rx_empty;

  // Register writes
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCDR_RESP_OKAY;
      ctrl_q <= `SCDR_CTRL_RESET;
      clock_period_divider_q <= `SCDR_DIV_RESET;
      hi_stage_q <= `SCDR_DATA_RESET;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `SCDR_RESP_OKAY : `SCDR_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_ctrl)
        ctrl_q <= (ctrl_q & ~ctrl_wmask) | (w_data_q[15:0] & ctrl_wmask);
      if (wr_div)
        clock_period_divider_q <= w_data_q[DIV_W-1:0];
      if (kill)
        hi_stage_q <= `SCDR_DATA_RESET;
      else if (wr_hi)
        hi_stage_q <= w_data_q[15:0];
    end
  end

  // Interrupt flag, set wins over clear
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      int_q <= 1'b0;
    else if (kill)
      int_q <= 1'b0;
    else if (rx_push)
      int_q <= 1'b1;
    else if (wr_clr)
      int_q <= 1'b0;
  end
  assign irq = int_rd & ctrl_q[`SCDR_B_IRQ_MASK];

  // FIFOs
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tx_wp_q <= {PTR_W{1'b0}};
      tx_rp_q <= {PTR_W{1'b0}};
      tx_cnt_q <= {(PTR_W+1){1'b0}};
      rx_wp_q <= {PTR_W{1'b0}};
      rx_rp_q <= {PTR_W{1'b0}};
      rx_cnt_q <= {(PTR_W+1){1'b0}};
    end
    else if (kill)
    begin
      tx_wp_q <= {PTR_W{1'b0}};
      tx_rp_q <= {PTR_W{1'b0}};
      tx_cnt_q <= {(PTR_W+1){1'b0}};
      rx_wp_q <= {PTR_W{1'b0}};
      rx_rp_q <= {PTR_W{1'b0}};
      rx_cnt_q <= {(PTR_W+1){1'b0}};
    end
    else
    begin
      if (tx_push)
        tx_wp_q <= tx_wp_q + 1'b1;
      if (tx_pop)
        tx_rp_q <= tx_rp_q + 1'b1;
      if (tx_push & ~tx_pop)
        tx_cnt_q <= tx_cnt_q + 1'b1;
      else if (tx_pop & ~tx_push)
        tx_cnt_q <= tx_cnt_q - 1'b1;
      if (rx_push)
        rx_wp_q <= rx_wp_q + 1'b1;
      if (rx_pop)
        rx_rp_q <= rx_rp_q + 1'b1;
      if (rx_push & ~rx_pop)
        rx_cnt_q <= rx_cnt_q + 1'b1;
      else if (rx_pop & ~rx_push)
        rx_cnt_q <= rx_cnt_q - 1'b1;
    end
  end

  // FIFO storage
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_entry
      always @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          tx_mem_q[gi] <= 32'h00000000;
          rx_mem_q[gi] <= 32'h00000000;
        end
        else
        begin
          if (tx_push & (tx_wp_q == gi))
            tx_mem_q[gi] <= {hi_stage_q, w_data_q[15:0]};
          if (rx_push & (rx_wp_q == gi))
            rx_mem_q[gi] <= rx_next;
        end
      end
    end
  endgenerate

  // Register reads
  reg [31:0] rd_val;
  reg rd_hit;
  always @*
  begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    if (rd_idx == (`SCDR_IDX_CTRL & `SCDR_IDX_MASK))
    begin
      rd_val[15:0] = ctrl_q & `SCDR_CTRL_RW_MASK;
      rd_val[`SCDR_B_INT] = int_rd;
      rd_val[`SCDR_B_PIN_SAMPLE] = din_s2_q;
      rd_val[`SCDR_B_TX_FULL] = tx_full;
    end
    else if (rd_idx == (`SCDR_IDX_DATA_LO & `SCDR_IDX_MASK))
      rd_val[15:0] = rx_head[15:0];
    else if (rd_idx == (`SCDR_IDX_DATA_HI & `SCDR_IDX_MASK))
      rd_val[15:0] = rx_head[31:16];
    else if (rd_idx == (`SCDR_IDX_IRQ_CLR & `SCDR_IDX_MASK))
      rd_val = 32'h00000000;
    else if (rd_idx == (`SCDR_IDX_DIVIDER & `SCDR_IDX_MASK))
      rd_val[DIV_W-1:0] = clock_period_divider_q;
    else
      rd_hit = 1'b0;
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCDR_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? `SCDR_RESP_OKAY : `SCDR_RESP_SLVERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // scdr_top

/* tb/scdr_chk.sv */
`timescale 1ns/1ps
module scdr_chk #(
  parameter ADDR_W = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  // Interrupt
  input wire irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire [11:0] ra = s_axi_araddr[13:2];
  wire [11:0] wa = s_axi_awaddr[13:2];
  wire ar_t = s_axi_arvalid && s_axi_arready;
  wire wr_t = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rmap = ra == 12'h200 || ra == 12'h202 || ra == 12'h204 || ra == 12'h206 || ra == 12'h210;
  wire wmap = wa == 12'h200 || wa == 12'h202 || wa == 12'h204 || wa == 12'h206 || wa == 12'h210;
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  rd_answer_a: assert property (ar_t |=> s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answering");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  rd_unmap_a: assert property (ar_t && !rmap |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  wr_unmap_a: assert property (wr_t && !wmap |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
  clr_read_a: assert property (ar_t && ra == 12'h206 |=> s_axi_rdata == 32'h0)
    else $error("clear register read not zero");
  clr_irq_a: assert property (wr_t && wa == 12'h206 |-> ##[1:3] !irq)
    else $error("interrupt not cleared");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits set");
endmodule // scdr_chk
bind scdr_top scdr_chk #(.ADDR_W(ADDR_W)) chk_i (.clk_sys(clk_sys), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq));

/* tb/scdr_peer.sv */
`timescale 1ns/1ps
module scdr_peer (
  // Serial lines
  input wire sclk,
  input wire mosi,
  output wire miso,
  // Frame setup
  input wire pol,
  input wire pha,
  input wire [5:0] nbits,
  input wire [31:0] load,
  input wire arm,
  // Captured word
  output reg [31:0] got
);
  reg [31:0] sh = 32'h0;
  reg first = 1'b1;
  // Released line shows the inverse of the last bit
  assign miso = arm ? sh[31] : ~sh[31];
  always @(posedge arm)
  begin
    sh = load << (32 - nbits);
    got = 32'h0;
    first = 1'b1;
  end
  // Leading edge leaves the idle level
  always @(sclk)
  begin
    if (arm && ((sclk != pol) ^ pha))
      got = {got[30:0], mosi};
    else if (arm && !first)
      sh = sh << 1;
    first = first && !arm;
  end
endmodule // scdr_peer

/* tb/scdr_top_tb.sv */
`timescale 1ns/1ps
module scdr_top_tb;
  reg clk_sys = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  reg dsel = 0, dtb = 0, pol = 0, pha = 0, arm = 0, m, ssn = 1;
  reg [15:0] awa = 0, ara = 0, c;
  reg [31:0] wd = 0, ld = 0, rdv, tx, rx, msk;
  reg [1:0] rsp, wc, cc;
  reg [5:0] nb;
  integer err_count = 0, tests_run = 0, k, dv, hf;
  real t0 = 0.0, per = 0.0;
  wire awr, wr, bv, arr, rv, sclk, sclk_oe_n, dout, dout_oe_n, irq, miso;
  wire [1:0] bre, rre;
  wire [31:0] rd, got;
  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge sclk)
  begin
    per = $realtime - t0;
    t0 = $realtime;
  end
  scdr_top dut (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bre),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rre),
    .sclk_o(sclk), .sclk_oe_n(sclk_oe_n), .sclk_i(1'b0), .serial_out_pin(dout),
    .serial_out_oe_n(dout_oe_n), .serial_in_pin(dsel ? dtb : miso), .slave_sel_n(ssn),
    .irq(irq));
  scdr_peer peer (.sclk(sclk), .mosi(dout), .miso(miso), .pol(pol), .pha(pha),
    .nbits(nb), .load(ld), .arm(arm), .got(got));
  task summarize;
    begin
      $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // One bus transfer; response ready held from the start until the answer
  task bus(input w, input [15:0] a, input [31:0] d);
    integer n;
    reg ta, tw, tr, hs;
    begin
      @(posedge clk_sys);
      awv <= w;
      wv <= w;
      arv <= !w;
      br <= w;
      rr <= !w;
      awa <= a;
      ara <= a;
      wd <= d;
      hs = 0;
      for (n = 0; n < 100 && !hs; n = n + 1)
      begin
        @(negedge clk_sys);
        ta = awv && awr;
        tw = wv && wr;
        tr = arv && arr;
        hs = w ? bv : rv;
        rsp = w ? bre : rre;
        rdv = rd;
        @(posedge clk_sys);
        if (ta) awv <= 0;
        if (tw) wv <= 0;
        if (tr) arv <= 0;
        if (hs)
        begin
          br <= 0;
          rr <= 0;
        end
      end
      if (!hs)
      begin
        err_count = err_count + 1;
        summarize;
      end
    end
  endtask
  task poll;
    integer n;
    begin
      rdv = 0;
      for (n = 0; n < 400 && !rdv[13]; n = n + 1)
        bus(0, 16'h0800, 0);
      if (!rdv[13])
      begin
        err_count = err_count + 1;
        summarize;
      end
    end
  endtask
  initial
  begin
    k = $urandom(16984);
    repeat (5) @(posedge clk_sys);
    rst <= 0;
    bus(0, 16'h0800, 0);
    chk(rdv, 0);
    bus(0, 16'h0818, 0);
    chk(rdv, 0);
    bus(0, 16'h0820, 0);
    chk(rsp, 2'h2);
    bus(1, 16'h0820, 1);
    chk(rsp, 2'h2);
    $display("Test reset done");
    for (k = 0; k < 8; k = k + 1)
    begin
      wc = k[1:0];
      cc = k[1:0] ^ {k[2], k[2]};
      m = $urandom % 2;
      tx = $urandom;
      nb = wc == 0 ? 8 : wc == 1 ? 16 : wc == 2 ? 32 : 9;
      msk = nb == 32 ? 32'hffffffff : (32'h1 << nb) - 1;
      dv = cc == 2 ? 3 : 2;
      hf = dv * (cc == 0 ? 4 : cc == 1 ? 2 : cc == 2 ? 1 : 7);
      c = {1'b0, m, 5'h0, wc, 2'h0, cc, k[2], k[0] ^ k[1], 1'b0};
      ld <= $urandom;
      bus(1, 16'h0840, dv);
      bus(1, 16'h0800, c);
      bus(0, 16'h0800, 0);
      chk(rdv & 32'hefff, c);
      pol <= k[2];
      pha <= k[0] ^ k[1];
      arm <= 1;
      bus(1, 16'h0800, c | 16'h1);
      if (nb == 32) bus(1, 16'h0810, tx[31:16]);
      bus(1, 16'h0808, tx[15:0]);
      poll;
      @(negedge clk_sys);
      chk(irq, m);
      chk(per, 2 * hf * 25);
      chk(sclk, k[2]);
      chk(dout, 0);
      bus(1, 16'h0818, $urandom);
      bus(0, 16'h0800, 0);
      chk(rdv[13], 0);
      @(negedge clk_sys);
      chk(irq, 0);
      rx = 0;
      if (nb == 32) bus(0, 16'h0810, 0);
      if (nb == 32) rx = rdv << 16;
      bus(0, 16'h0808, 0);
      rx = rx | rdv[15:0];
      chk(rx & msk, ld & msk);
      chk(got & msk, tx & msk);
      arm <= 0;
      $display("Test %0d done", k);
    end
    for (k = 0; k < 2; k = k + 1)
    begin
      dsel <= 1;
      dtb <= k[0];
      repeat (3) @(posedge clk_sys);
      bus(0, 16'h0800, 0);
      chk(rdv[12], k[0]);
    end
    $display("Test input sample done");
    bus(1, 16'h0800, 16'h0021);
    @(negedge clk_sys);
    chk(dout, 1);
    bus(1, 16'h0800, 16'h0421);
    bus(1, 16'h0808, 16'h0000);
    for (k = 0; k < 20; k = k + 1)
    begin
      @(negedge clk_sys);
      chk(dout, 1);
    end
    $display("Test force done");
    bus(1, 16'h0800, 16'h8040);
    bus(1, 16'h0800, 16'h8041);
    @(negedge clk_sys);
    chk(dout_oe_n, 1);
    chk(sclk_oe_n, 1);
    @(posedge clk_sys);
    ssn <= 0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(dout_oe_n, 0);
    @(posedge clk_sys);
    ssn <= 1;
    bus(1, 16'h0800, 16'h0041);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(dout_oe_n, 0);
    bus(1, 16'h0800, 16'h0200);
    $display("Test slave done");
    bus(1, 16'h0840, 16'h00ff);
    bus(1, 16'h0800, 16'h0019);
    for (k = 0; k < 5; k = k + 1)
      bus(1, 16'h0808, $urandom);
    bus(0, 16'h0800, 0);
    chk(rdv[11], 1);
    bus(1, 16'h0800, 16'h0219);
    bus(0, 16'h0800, 0);
    chk(rdv[11], 0);
    $display("Test full done");
    summarize;
  end
endmodule // scdr_top_tb
